// File: fsp_pkg.sv
// Shared constants and types for the framed serial port.
package fsp_pkg;

    // Word and FIFO geometry.
    localparam int WORD_W     = 16;
    localparam int FIFO_DEPTH = 4;

    // Control register field positions.
    localparam int B_DLB  = 0;
    localparam int B_TXM  = 1;
    localparam int B_MCM  = 2;
    localparam int B_FSM  = 3;
    localparam int B_TRANSMIT_RESET_BIT = 4;
    localparam int B_RECEIVE_RESET_BIT = 5;
    localparam int B_OVF  = 6;
    localparam int B_RNE  = 7;
    localparam int B_TNE  = 8;
    localparam int B_SOFT = 14;
    localparam int B_FREE = 15;

    // Reset value and the bits that a control write stores.
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [15:0] CTL_WMASK = 16'hC03F;

    // Internal transmit clock: half period in ns, and in system cycles.
    localparam int CLK_PERIOD_PS    = 8000;
    localparam int INT_CLK_HALF_NS  = 80;
    localparam int INT_CLK_HALF_CYC =
        (INT_CLK_HALF_NS * 1000 / CLK_PERIOD_PS) < 1 ? 1 :
        (INT_CLK_HALF_NS * 1000 / CLK_PERIOD_PS);

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_LOADED,
        TX_SYNC,
        TX_SHIFT
    } fsp_tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_ARMED,
        RX_SHIFT
    } fsp_rx_state_t;

endpackage

// File: fsp_sync.sv
// Two-stage synchroniser for a group of pin inputs.
module fsp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         sys_rst,
    // Pins and their synchronised copies
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = pin_i;
        sync_d = meta_q;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;

endmodule

// File: fsp_fifo.sv
// Small first-in first-out store held in flip-flops.
module fsp_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 4,
    parameter int CW    = $clog2(DEPTH) + 1
) (
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          rst,
    // Write side; a push while full is dropped
    input  wire logic          push,
    input  wire logic [W-1:0]  push_data,
    // Read side; a pop while empty is ignored
    input  wire logic          pop,
    output logic      [W-1:0]  head,
    // Level
    output logic               full,
    output logic               empty,
    output logic      [CW-1:0] count
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0]  mem_q [DEPTH];
    logic [W-1:0]  mem_d [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] wr_d;
    logic [AW-1:0] rd_q;
    logic [AW-1:0] rd_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          do_push;
    logic          do_pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    always_comb begin
        do_push = push && (cnt_q != CW'(DEPTH));
        do_pop  = pop && (cnt_q != '0);
        mem_d   = mem_q;
        wr_d    = wr_q;
        rd_d    = rd_q;
        cnt_d   = cnt_q;
        if (do_push) begin
            mem_d[wr_q] = push_data;
            wr_d        = bump(wr_q);
        end
        if (do_pop) begin
            rd_d = bump(rd_q);
        end
        if (do_push && !do_pop) begin
            cnt_d = cnt_q + CW'(1);
        end else if (do_pop && !do_push) begin
            cnt_d = cnt_q - CW'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            mem_q <= mem_d;
        end
    end

    assign head  = mem_q[rd_q];
    assign full  = (cnt_q == CW'(DEPTH));
    assign empty = (cnt_q == '0);
    assign count = cnt_q;

endmodule

// File: fsp_port.sv
// Frame-synchronised serial port: control, transmitter and receiver.
//
// Notes on behaviour
// - Both mode bits zero: continuous external-sync transmit.
// - One sync starts; runs until transmit FIFO empties.
// - Sync seen on falling edge loads shift register.
// - MSB on next rising edge; rest after sync low.
// - Next word follows at once, no new sync.
// - Four-word transmit FIFO; write when full lost.
// - Only resets leave continuous transmit mode.
// - Receive sync is input; software matches modes.
// - Fifth receive word rejected, sets overflow.
// - Burst: MSB on falling edge after sync falls.
// - Burst word stored if room; full raises flags.
// - Later burst words stored only when FIFO empty.
// - Sync mid-word restarts reception, bits dropped.
// - Continuous receive: one sync, back-to-back words.
// - Continuous loss sets overflow, blocks until read.
// - Continuous receive runs until burst mode or reset.
// - Breakpoint obeys free and soft stop bits.
// - Reset selects immediate stop.
// - Loopback bit ties transmit data, sync to receive.
// - Loopback with internal clock also ties clocks.
// - Word stored only after all sixteen bits.
module fsp_port #(
    parameter int WORD_W     = fsp_pkg::WORD_W,
    parameter int FIFO_DEPTH = fsp_pkg::FIFO_DEPTH,
    parameter int CLK_HALF   = fsp_pkg::INT_CLK_HALF_CYC
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              sys_rst,
    // Control register port
    input  wire logic              ctl_wr,
    input  wire logic [15:0]       ctl_wdata,
    output logic      [15:0]       ctl_rdata,
    // Data register port
    input  wire logic              data_wr,
    input  wire logic [WORD_W-1:0] data_wdata,
    input  wire logic              data_rd,
    output logic      [WORD_W-1:0] data_rdata,
    // Emulation breakpoint from the processor
    input  wire logic              emu_halt,
    // Transmit link
    input  wire logic              transmit_clock_i,
    output logic                   transmit_clock_o,
    output logic                   transmit_clock_oe,
    input  wire logic              transmit_frame_sync,
    output logic                   transmit_data_pin,
    // Receive link
    input  wire logic              receive_clock,
    input  wire logic              receive_frame_sync,
    input  wire logic              receive_data_pin,
    // Events to the processor
    output logic                   transmit_interrupt,
    output logic                   receive_interrupt
);

    localparam int CW  = $clog2(FIFO_DEPTH) + 1;
    localparam int TCW = $clog2(WORD_W) + 1;
    localparam int RCW = $clog2(WORD_W);
    localparam int DW  = $clog2(CLK_HALF) + 1;

    // Control state.
    logic [15:0]         ctl_q;
    logic [15:0]         ctl_d;
    logic [15:0]         crd_q;
    logic [15:0]         crd_d;
    logic [WORD_W-1:0]   drd_q;
    logic [WORD_W-1:0]   drd_d;
    logic                tx_cont_q;
    logic                tx_cont_d;
    logic                loopback_bit;
    logic                transmit_sync_source_bit;
    logic                internal_clock_source_bit;
    logic                fsm;
    logic                tx_rst;
    logic                rx_rst;
    logic                stop_now;
    logic                stop_soft;

    // Clock generation and link edges.
    logic [DW-1:0]       div_q;
    logic [DW-1:0]       div_d;
    logic                iclk_q;
    logic                iclk_d;
    logic [4:0]          pin_s;
    logic [4:0]          prev_q;
    logic                tick;
    logic                irise;
    logic                ifall;
    logic                tx_rise;
    logic                tx_fall;
    logic                rx_fall;
    logic                tfs;
    logic                rfs;
    logic                rbit;

    // Transmitter.
    fsp_pkg::fsp_tx_state_t tx_st_q;
    fsp_pkg::fsp_tx_state_t tx_st_d;
    logic [WORD_W-1:0]   xsr_q;
    logic [WORD_W-1:0]   xsr_d;
    logic [TCW-1:0]      tcnt_q;
    logic [TCW-1:0]      tcnt_d;
    logic                tdat_q;
    logic                tdat_d;
    logic                txint_q;
    logic                txint_d;
    logic                tpop;
    logic [WORD_W-1:0]   tf_head;
    logic                tf_empty;
    logic [CW-1:0]       tf_cnt;

    // Receiver.
    fsp_pkg::fsp_rx_state_t rx_st_q;
    fsp_pkg::fsp_rx_state_t rx_st_d;
    logic [WORD_W-1:0]   rsr_q;
    logic [WORD_W-1:0]   rsr_d;
    logic [RCW-1:0]      rcnt_q;
    logic [RCW-1:0]      rcnt_d;
    logic                ovf_q;
    logic                ovf_d;
    logic                block_q;
    logic                block_d;
    logic                seen_q;
    logic                seen_d;
    logic                rxint_q;
    logic                rxint_d;
    logic                rpush;
    logic                rpop;
    logic [WORD_W-1:0]   rword;
    logic [WORD_W-1:0]   rf_head;
    logic                rf_full;
    logic                rf_empty;
    logic [CW-1:0]       rf_cnt;
    logic                accept;

    assign loopback_bit    = ctl_q[fsp_pkg::B_DLB];
    assign transmit_sync_source_bit    = ctl_q[fsp_pkg::B_TXM];
    assign internal_clock_source_bit    = ctl_q[fsp_pkg::B_MCM];
    assign fsm    = ctl_q[fsp_pkg::B_FSM];
    // Clearing a reset bit holds that half of the port idle.
    assign tx_rst = sys_rst || !ctl_q[fsp_pkg::B_TRANSMIT_RESET_BIT];
    assign rx_rst = sys_rst || !ctl_q[fsp_pkg::B_RECEIVE_RESET_BIT];

    // Free set runs on; soft alone finishes the word; neither aborts.
    assign stop_now  = emu_halt && !ctl_q[fsp_pkg::B_FREE]
                       && !ctl_q[fsp_pkg::B_SOFT];
    assign stop_soft = emu_halt && !ctl_q[fsp_pkg::B_FREE]
                       && ctl_q[fsp_pkg::B_SOFT];

    fsp_sync #(
        .W (5)
    ) u_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .pin_i   ({receive_data_pin, receive_frame_sync, receive_clock,
                   transmit_frame_sync, transmit_clock_i}),
        .sync_o  (pin_s)
    );

    // Control and read-back registers.
    always_comb begin
        ctl_d = ctl_q;
        if (ctl_wr) begin
            ctl_d = ctl_wdata & fsp_pkg::CTL_WMASK;
        end
        // The mode is caught only while the transmitter is held in reset.
        tx_cont_d = tx_cont_q;
        if (tx_rst) begin
            tx_cont_d = !fsm && !transmit_sync_source_bit;
        end
        crd_d = ctl_q;
        crd_d[fsp_pkg::B_OVF] = ovf_q;
        crd_d[fsp_pkg::B_RNE] = !rf_empty;
        crd_d[fsp_pkg::B_TNE] = !tf_empty;
        rpop  = data_rd && !rf_empty;
        drd_d = rpop ? rf_head : drd_q;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctl_q     <= fsp_pkg::CTL_RESET;
            tx_cont_q <= 1'b0;
            crd_q     <= fsp_pkg::CTL_RESET;
            drd_q     <= '0;
        end else begin
            ctl_q     <= ctl_d;
            tx_cont_q <= tx_cont_d;
            crd_q     <= crd_d;
            drd_q     <= drd_d;
        end
    end

    // Internal transmit clock and edge detection on the link.
    always_comb begin
        tick   = (div_q == DW'(CLK_HALF - 1));
        div_d  = tick ? '0 : div_q + DW'(1);
        iclk_d = tick ? !iclk_q : iclk_q;
        irise  = tick && !iclk_q;
        ifall  = tick && iclk_q;
        tx_rise = internal_clock_source_bit ? irise : (pin_s[0] && !prev_q[0]);
        tx_fall = internal_clock_source_bit ? ifall : (!pin_s[0] && prev_q[0]);
        // In loopback the receiver takes sync and data from the transmit side, and the clock too when internal.
        if (loopback_bit && internal_clock_source_bit) begin
            rx_fall = ifall;
        end else begin
            rx_fall = !pin_s[2] && prev_q[2];
        end
        tfs  = pin_s[1];
        rfs  = loopback_bit ? pin_s[1] : pin_s[3];
        rbit = loopback_bit ? tdat_q : pin_s[4];
    end

    always_ff @(posedge clock) begin
        if (sys_rst || !internal_clock_source_bit) begin
            div_q  <= '0;
            iclk_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            iclk_q <= iclk_d;
        end
        if (sys_rst) begin
            prev_q <= '0;
        end else begin
            prev_q <= pin_s;
        end
    end

    fsp_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clock     (clock),
        .rst       (tx_rst),
        .push      (data_wr),
        .push_data (data_wdata),
        .pop       (tpop),
        .head      (tf_head),
        .full      (),
        .empty     (tf_empty),
        .count     (tf_cnt)
    );

    // Transmitter sequence.
    always_comb begin
        tx_st_d = tx_st_q;
        xsr_d   = xsr_q;
        tcnt_d  = tcnt_q;
        tdat_d  = tdat_q;
        txint_d = 1'b0;
        tpop    = 1'b0;
        if (stop_now) begin
            tx_st_d = fsp_pkg::TX_IDLE;
        end else if (!(stop_soft && tx_st_q == fsp_pkg::TX_IDLE)) begin
            case (tx_st_q)
                fsp_pkg::TX_IDLE: begin
                    // An empty FIFO makes the sync pass unnoticed.
                    if (tx_fall && tfs && !tf_empty && tx_cont_q) begin
                        xsr_d   = tf_head;
                        tpop    = 1'b1;
                        txint_d = (tf_cnt == CW'(1));
                        tx_st_d = fsp_pkg::TX_LOADED;
                    end
                end
                fsp_pkg::TX_LOADED: begin
                    if (tx_rise) begin
                        tdat_d  = xsr_q[WORD_W-1];
                        xsr_d   = xsr_q << 1;
                        tcnt_d  = TCW'(1);
                        tx_st_d = fsp_pkg::TX_SYNC;
                    end
                end
                fsp_pkg::TX_SYNC: begin
                    // Shifting waits for the sync to drop.
                    if (!tfs) begin
                        tx_st_d = fsp_pkg::TX_SHIFT;
                    end
                end
                fsp_pkg::TX_SHIFT: begin
                    if (tx_rise && tcnt_q == TCW'(WORD_W)) begin
                        if (!tf_empty && !stop_soft) begin
                            tdat_d  = tf_head[WORD_W-1];
                            xsr_d   = tf_head << 1;
                            tpop    = 1'b1;
                            txint_d = (tf_cnt == CW'(1));
                            tcnt_d  = TCW'(1);
                        end else begin
                            tx_st_d = fsp_pkg::TX_IDLE;
                        end
                    end else if (tx_rise) begin
                        tdat_d = xsr_q[WORD_W-1];
                        xsr_d  = xsr_q << 1;
                        tcnt_d = tcnt_q + TCW'(1);
                    end
                end
                default: tx_st_d = fsp_pkg::TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (tx_rst) begin
            tx_st_q <= fsp_pkg::TX_IDLE;
            xsr_q   <= '0;
            tcnt_q  <= '0;
            tdat_q  <= 1'b0;
            txint_q <= 1'b0;
        end else begin
            tx_st_q <= tx_st_d;
            xsr_q   <= xsr_d;
            tcnt_q  <= tcnt_d;
            tdat_q  <= tdat_d;
            txint_q <= txint_d;
        end
    end

    fsp_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clock     (clock),
        .rst       (rx_rst),
        .push      (rpush),
        .push_data (rword),
        .pop       (rpop),
        .head      (rf_head),
        .full      (rf_full),
        .empty     (rf_empty),
        .count     (rf_cnt)
    );

    // Receiver sequence; burst or continuous follows the live mode bit.
    always_comb begin
        rx_st_d = rx_st_q;
        rsr_d   = rsr_q;
        rcnt_d  = rcnt_q;
        ovf_d   = ovf_q;
        seen_d  = seen_q;
        rxint_d = 1'b0;
        rpush   = 1'b0;
        rword   = {rsr_q[WORD_W-2:0], rbit};
        // A read frees space, which lifts the block; a new loss wins.
        block_d = data_rd ? 1'b0 : block_q;
        if (fsm) begin
            accept = seen_q ? rf_empty : !rf_full;
        end else begin
            accept = !rf_full && !block_q;
        end
        if (stop_now) begin
            rx_st_d = fsp_pkg::RX_IDLE;
        end else if (rx_fall && !(stop_soft && rx_st_q != fsp_pkg::RX_SHIFT))
        begin
            if (rfs) begin
                rx_st_d = fsp_pkg::RX_ARMED;
                rcnt_d  = '0;
            end else begin
                case (rx_st_q)
                    fsp_pkg::RX_ARMED: begin
                        rsr_d   = rword;
                        rcnt_d  = RCW'(1);
                        rx_st_d = fsp_pkg::RX_SHIFT;
                    end
                    fsp_pkg::RX_SHIFT: begin
                        rsr_d  = rword;
                        rcnt_d = rcnt_q + RCW'(1);
                        if (rcnt_q == RCW'(WORD_W - 1)) begin
                            seen_d = 1'b1;
                            rcnt_d = '0;
                            if (accept) begin
                                rpush = 1'b1;
                                if (rf_cnt == CW'(FIFO_DEPTH - 1)) begin
                                    rxint_d = 1'b1;
                                    ovf_d   = ovf_q || fsm;
                                end
                            end else begin
                                ovf_d   = 1'b1;
                                rxint_d = !fsm;
                                block_d = !fsm;
                            end
                            // Continuous keeps shifting; burst waits.
                            if (fsm || stop_soft) begin
                                rx_st_d = fsp_pkg::RX_IDLE;
                            end
                        end
                    end
                    fsp_pkg::RX_IDLE: rx_st_d = fsp_pkg::RX_IDLE;
                    default: rx_st_d = fsp_pkg::RX_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rx_rst) begin
            rx_st_q <= fsp_pkg::RX_IDLE;
            rsr_q   <= '0;
            rcnt_q  <= '0;
            ovf_q   <= 1'b0;
            block_q <= 1'b0;
            seen_q  <= 1'b0;
            rxint_q <= 1'b0;
        end else begin
            rx_st_q <= rx_st_d;
            rsr_q   <= rsr_d;
            rcnt_q  <= rcnt_d;
            ovf_q   <= ovf_d;
            block_q <= block_d;
            seen_q  <= seen_d;
            rxint_q <= rxint_d;
        end
    end

    assign ctl_rdata          = crd_q;
    assign data_rdata         = drd_q;
    assign transmit_clock_o   = iclk_q;
    assign transmit_clock_oe  = ctl_q[fsp_pkg::B_MCM];
    assign transmit_data_pin  = tdat_q;
    assign transmit_interrupt = txint_q;
    assign receive_interrupt  = rxint_q;

endmodule

// File: fsp_port_assertions.sv
// Concurrent checks on the serial port's register and event ports.
module fsp_port_assertions (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // Register side
    input  wire logic        ctl_wr,
    input  wire logic [15:0] ctl_wdata,
    input  wire logic [15:0] ctl_rdata,
    input  wire logic        data_wr,
    // Clock enable and events
    input  wire logic        transmit_clock_oe,
    input  wire logic        transmit_interrupt,
    input  wire logic        receive_interrupt
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    reset_default_a: assert property (
        $fell(sys_rst) |-> ctl_rdata == 16'h0000)
        else $error("control not cleared by reset");
    ctl_echo_a: assert property (
        ctl_wr ##1 !ctl_wr |-> ##1
        (ctl_rdata & 16'hC03F) == ($past(ctl_wdata, 2) & 16'hC03F))
        else $error("control write not read back");
    ovf_hold_a: assert property (
        ctl_rdata[6] && !ctl_wr && !$past(ctl_wr) && !$past(ctl_wr, 2)
        |=> ctl_rdata[6])
        else $error("overflow cleared without reset");
    ovf_cause_a: assert property (
        $rose(ctl_rdata[6]) |-> ctl_rdata[5])
        else $error("overflow while receiver held in reset");
    tx_pulse_a: assert property (
        transmit_interrupt |=> !transmit_interrupt)
        else $error("transmit event longer than one cycle");
    rx_pulse_a: assert property (
        receive_interrupt |=> !receive_interrupt)
        else $error("receive event longer than one cycle");
    tx_empty_a: assert property (
        transmit_interrupt |-> ##[0:3] !ctl_rdata[8])
        else $error("transmit event with words still queued");
    rx_full_a: assert property (
        receive_interrupt |-> ##[0:3] ctl_rdata[7])
        else $error("receive event with empty store");
    tx_stored_a: assert property (
        data_wr && ctl_rdata[4] |-> ##2 ctl_rdata[8])
        else $error("data write not queued");
    oe_match_a: assert property (
        1'b1 |=> ctl_rdata[2] == $past(transmit_clock_oe))
        else $error("clock enable differs from control bit");
endmodule

// File: fsp_codec_model.sv
// Behavioural codec on the far side of the serial link.
module fsp_codec_model (
    // Link lines driven by the codec
    output logic      link_clk,
    output logic      tx_fs,
    output logic      rx_fs,
    output logic      rx_dat,
    // Serial data from the port
    input  wire logic tx_dat
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] cap;
    logic [15:0] got_q [$];

    initial begin
        link_clk = 1'b0;
        tx_fs    = 1'b0;
        rx_fs    = 1'b0;
        rx_dat   = 1'b1;
    end

    // One link period: lines change on the rise, data is taken on the fall.
    task automatic beat(input logic fs, input logic d);
        link_clk = 1'b1;
        tx_fs    = fs;
        rx_fs    = fs;
        rx_dat   = d;
        #80;
        link_clk = 1'b0;
        cap      = {cap[14:0], tx_dat};
        #80;
    endtask

    // Optional cut-short word, one sync, then nw words; receive word k is
    // base + k. The small offset keeps link edges off the system clock.
    task automatic frame(input int nw, input logic [15:0] base,
                         input int cut);
        logic [15:0] w;
        #3;
        if (cut > 0) begin
            beat(1'b1, 1'b0);
            repeat (cut) beat(1'b0, 1'b1);
        end
        beat(1'b1, 1'b0);
        for (int k = 0; k < nw; k++) begin
            w = base + 16'(k);
            for (int b = 15; b >= 0; b--) beat(1'b0, w[b]);
            got_q.push_back(cap);
        end
        // The clock now stands still; a released line must not keep its bit.
        rx_dat = ~rx_dat;
    endtask
endmodule

// File: tb_top.sv
// Self-checking bench for the framed serial port.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock, sys_rst, emu_halt, clk_oe, iclk, iclk_was;
    logic        ctl_wr, data_wr, data_rd;
    logic [15:0] ctl_wdata, ctl_rdata, data_wdata, data_rdata;
    logic        link_clk, tx_fs, rx_fs, rx_dat, tx_dat, tx_irq, rx_irq;
    int          failures, comparisons, tx_irq_n, rx_irq_n;
    logic [15:0] txw [5] = '{16'h8001, 16'h4C3E, 16'hF0A5, 16'h0FF1,
                             16'hD00D};

    fsp_port #(.CLK_HALF(2)) dut_u (
        .clock               (clock),
        .sys_rst             (sys_rst),
        .ctl_wr              (ctl_wr),
        .ctl_wdata           (ctl_wdata),
        .ctl_rdata           (ctl_rdata),
        .data_wr             (data_wr),
        .data_wdata          (data_wdata),
        .data_rd             (data_rd),
        .data_rdata          (data_rdata),
        .emu_halt            (emu_halt),
        .transmit_clock_i    (link_clk),
        .transmit_clock_o    (iclk),
        .transmit_clock_oe   (clk_oe),
        .transmit_frame_sync (tx_fs),
        .transmit_data_pin   (tx_dat),
        .receive_clock       (link_clk),
        .receive_frame_sync  (rx_fs),
        .receive_data_pin    (rx_dat),
        .transmit_interrupt  (tx_irq),
        .receive_interrupt   (rx_irq)
    );

    fsp_codec_model codec_u (
        .link_clk (link_clk),
        .tx_fs    (tx_fs),
        .rx_fs    (rx_fs),
        .rx_dat   (rx_dat),
        .tx_dat   (tx_dat)
    );

    always #4 clock = ~clock;

    always @(posedge clock) begin
        tx_irq_n <= tx_irq_n + (tx_irq === 1'b1 ? 1 : 0);
        rx_irq_n <= rx_irq_n + (rx_irq === 1'b1 ? 1 : 0);
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic ctl_write(input logic [15:0] v);
        @(posedge clock);
        ctl_wr    <= 1'b1;
        ctl_wdata <= v;
        @(posedge clock);
        ctl_wr    <= 1'b0;
    endtask

    task automatic data_write(input logic [15:0] v);
        @(posedge clock);
        data_wr    <= 1'b1;
        data_wdata <= v;
        @(posedge clock);
        data_wr    <= 1'b0;
    endtask

    task automatic data_read(input logic [15:0] exp);
        @(posedge clock);
        data_rd <= 1'b1;
        @(posedge clock);
        data_rd <= 1'b0;
        @(posedge clock);
        check(data_rdata, exp);
    endtask

    // Readback lags a write by two cycles, so settle before comparing.
    task automatic ctl_check(input logic [15:0] mask, input logic [15:0] exp);
        repeat (3) @(posedge clock);
        check(ctl_rdata & mask, exp);
    endtask

    task automatic link(input int nw, input logic [15:0] base, input int cut);
        @(posedge clock);
        codec_u.frame(nw, base, cut);
    endtask

    task automatic final_report();
        if (failures == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        clock      = 1'b0;
        sys_rst    = 1'b1;
        emu_halt   = 1'b0;
        ctl_wr     = 1'b0;
        data_wr    = 1'b0;
        data_rd    = 1'b0;
        ctl_wdata  = 16'h0000;
        data_wdata = 16'h0000;
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        ctl_check(16'hFFFF, 16'h0000);
        ctl_write(16'h0004);
        data_write(16'h1111);
        check({15'h0000, clk_oe}, 16'h0001);
        #1 iclk_was = iclk;
        repeat (2) @(posedge clock);
        #1 check({15'h0000, iclk}, {15'h0000, ~iclk_was});
        ctl_check(16'hFFFF, 16'h0004);
        ctl_write(16'h0000);
        ctl_write(16'h0030);
        for (int i = 0; i < 5; i++) data_write(txw[i]);
        ctl_check(16'h01C0, 16'h0100);
        link(5, 16'hB3C0, 0);
        ctl_check(16'h01C0, 16'h00C0);
        for (int i = 0; i < 4; i++) begin
            check(codec_u.got_q[i], txw[i]);
            data_read(16'hB3C0 + 16'(i));
        end
        check(16'(tx_irq_n), 16'h0001);
        check(16'(rx_irq_n > 0), 16'h0001);
        ctl_write(16'h0008);
        ctl_write(16'h0038);
        ctl_check(16'hFFFF, 16'h0038);
        link(1, 16'h5A0F, 0);
        link(1, 16'h1234, 0);
        ctl_check(16'h00C0, 16'h00C0);
        data_read(16'h5A0F);
        link(1, 16'hC3A5, 5);
        data_read(16'hC3A5);
        ctl_check(16'h0080, 16'h0000);
        // Halted with free clear: nothing leaves or enters, word stays queued.
        emu_halt <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            ctl_write(16'h0001 | 16'(m) << 14);
            ctl_write(16'h0031 | 16'(m) << 14);
            data_write(16'h6B2D);
            link(1, 16'h0000, 0);
            ctl_check(16'h0180, 16'h0100);
        end
        ctl_write(16'h8001);
        ctl_write(16'h8031);
        emu_halt <= 1'b1;
        data_write(16'h9C3A);
        link(1, 16'h0000, 0);
        emu_halt <= 1'b0;
        data_read(16'h9C3A);
        final_report();
    end

    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        final_report();
    end
endmodule

bind fsp_port fsp_port_assertions chk_u (
    .clock              (clock),
    .sys_rst            (sys_rst),
    .ctl_wr             (ctl_wr),
    .ctl_wdata          (ctl_wdata),
    .ctl_rdata          (ctl_rdata),
    .data_wr            (data_wr),
    .transmit_clock_oe  (transmit_clock_oe),
    .transmit_interrupt (transmit_interrupt),
    .receive_interrupt  (receive_interrupt)
);
